// file: drm_cfg.svh
// register map, field positions and bus codes of the row mask and delay block
`ifndef DRM_CFG_SVH
`define DRM_CFG_SVH
`define DRM_OFS_ROWMASK   12'h000
`define DRM_OFS_DLY       12'h004
`define DRM_OFS_LOWBITS   12'h008
`define DRM_OFS_STATUS    12'h00C
`define DRM_ROWMASK_W     13
`define DRM_DLY_W         31
`define DRM_RST_ROWMASK   13'h0000
`define DRM_RST_DLY       31'h00000000
`define DRM_RST_LOWBITS   16'h0000
`define DRM_SRMIN_LSB     0
`define DRM_SREXLO_LSB    8
`define DRM_PDMIN_LSB     16
`define DRM_PDEX_LSB      20
`define DRM_WPHI_BIT      26
`define DRM_W2RHI_BIT     27
`define DRM_W2RCSHI_BIT   28
`define DRM_NDRHI_BIT     29
`define DRM_SREXHI_BIT    30
`define DRM_NDRLO_LSB     0
`define DRM_W2RCSLO_LSB   4
`define DRM_W2RLO_LSB     8
`define DRM_WPLO_LSB      12
`define DRM_ST_STATE_LSB  0
`define DRM_ST_CNT_LSB    16
`define DRM_RESP_OKAY     2'h0
`define DRM_RESP_DECERR   2'h3
`endif

// file: drm_pkg.sv
// types shared by the row mask and delay block
package drm_pkg;
  typedef enum logic [2:0] {
    DRM_CMD_WRITE    = 3'h0,
    DRM_CMD_READ     = 3'h1,
    DRM_CMD_PRECHG   = 3'h2,
    DRM_CMD_SR_ENTER = 3'h3,
    DRM_CMD_SR_EXIT  = 3'h4,
    DRM_CMD_PD_ENTER = 3'h5,
    DRM_CMD_PD_EXIT  = 3'h6
  } drm_cmd_kind_t;

  typedef struct packed {
    drm_cmd_kind_t kind;
    logic [0:0]    cs;
    logic [2:0]    bank;
  } drm_cmd_t;

  typedef enum logic [2:0] {
    DRM_ST_ACTIVE  = 3'h0,
    DRM_ST_SELFREF = 3'h1,
    DRM_ST_SR_EXIT = 3'h2,
    DRM_ST_PWRDN   = 3'h3,
    DRM_ST_PD_EXIT = 3'h4
  } drm_pwr_state_t;
endpackage

// file: drm_ctrl.sv
// row mask and command spacing slice of the ddr2 controller, with axi4-lite registers
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`include "drm_cfg.svh"

module drm_ctrl #(
  parameter int ADDR_W   = 32,
  parameter int NUM_BANK = 8
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // axi4-lite slave
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // row address derivation
  input  wire logic [ADDR_W-1:0]      user_addr,
  input  wire logic [4:0]             row_bit_position,
  output logic [`DRM_ROWMASK_W-1:0]   row_addr,
  // command gate
  input  wire logic                   cmd_valid,
  input  wire drm_pkg::drm_cmd_t      cmd,
  output logic                        cmd_ready,
  output logic                        next_data_request
);
  import drm_pkg::*;

  // register storage
  logic [`DRM_ROWMASK_W-1:0] row_select_mask_r;
  logic [`DRM_DLY_W-1:0]     dly_r;
  logic [15:0]               lowbits_r;

  // bus channel state
  logic        aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;

  // fields of the delay registers
  wire [7:0] selfrefresh_min_stay  = dly_r[`DRM_SRMIN_LSB +: 8];
  wire [8:0] selfrefresh_exit_wait = {dly_r[`DRM_SREXHI_BIT], dly_r[`DRM_SREXLO_LSB +: 8]};
  wire [3:0] powerdown_min_stay    = dly_r[`DRM_PDMIN_LSB +: 4];
  wire [5:0] powerdown_exit_wait   = dly_r[`DRM_PDEX_LSB +: 6];
  wire [4:0] next_data_request_spacing   = {dly_r[`DRM_NDRHI_BIT], lowbits_r[`DRM_NDRLO_LSB +: 4]};
  wire [4:0] write_read_cross_cs_spacing = {dly_r[`DRM_W2RCSHI_BIT], lowbits_r[`DRM_W2RCSLO_LSB +: 4]};
  wire [4:0] write_read_same_cs_spacing  = {dly_r[`DRM_W2RHI_BIT], lowbits_r[`DRM_W2RLO_LSB +: 4]};
  wire [4:0] write_precharge_spacing     = {dly_r[`DRM_WPHI_BIT], lowbits_r[`DRM_WPLO_LSB +: 4]};

  // spacing state
  drm_pwr_state_t state_r, state_nxt;
  logic [8:0] pwr_cnt_r, pwr_cnt_nxt;
  logic [4:0] same_cnt_r, cross_cnt_r, ndr_cnt_r;
  logic [4:0] wp_cnt_r [NUM_BANK];
  logic [0:0] last_wr_cs_r;
  logic       ndr_pend_r, ndr_r;
  logic [`DRM_ROWMASK_W-1:0] row_addr_r;

  // ---------------- axi4-lite write path ----------------
  wire aw_take   = s_axi_awvalid && !aw_have_r;
  wire w_take    = s_axi_wvalid && !w_have_r;
  wire wr_fire   = aw_have_r && w_have_r && !bvalid_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire hit_wmask = awaddr_r == `DRM_OFS_ROWMASK;
  wire hit_wdly  = awaddr_r == `DRM_OFS_DLY;
  wire hit_wlow  = awaddr_r == `DRM_OFS_LOWBITS;
  wire hit_wstat = awaddr_r == `DRM_OFS_STATUS;
  wire w_mapped  = hit_wmask || hit_wdly || hit_wlow || hit_wstat;
  wire [31:0] mask_merge = ({19'h00000, row_select_mask_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] dly_merge  = ({1'b0, dly_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] low_merge  = ({16'h0000, lowbits_r} & ~wmask) | (wdata_r & wmask);

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready  = !w_have_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_have_r <= 1'b0;
      awaddr_r  <= 12'h000;
    end else if (aw_take) begin
      aw_have_r <= 1'b1;
      awaddr_r  <= {s_axi_awaddr[11:2], 2'h0};
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_have_r <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
    end else if (w_take) begin
      w_have_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `DRM_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= w_mapped ? `DRM_RESP_OKAY : `DRM_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // unimplemented bits are never stored, so they read back as zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_select_mask_r <= `DRM_RST_ROWMASK;
      dly_r             <= `DRM_RST_DLY;
      lowbits_r         <= `DRM_RST_LOWBITS;
    end else if (wr_fire) begin
      if (hit_wmask) row_select_mask_r <= mask_merge[`DRM_ROWMASK_W-1:0];
      if (hit_wdly)  dly_r <= dly_merge[`DRM_DLY_W-1:0];
      if (hit_wlow)  lowbits_r <= low_merge[15:0];
    end
  end

  // ---------------- axi4-lite read path ----------------
  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire [11:0] ar_word = {s_axi_araddr[11:2], 2'h0};
  wire [31:0] status_word = (32'(pwr_cnt_r) << `DRM_ST_CNT_LSB) | (32'(state_r) << `DRM_ST_STATE_LSB);
  wire [31:0] rd_mux =
    (ar_word == `DRM_OFS_ROWMASK) ? {19'h00000, row_select_mask_r} :
    (ar_word == `DRM_OFS_DLY)     ? {1'b0, dly_r} :
    (ar_word == `DRM_OFS_LOWBITS) ? {16'h0000, lowbits_r} :
    (ar_word == `DRM_OFS_STATUS)  ? status_word : 32'h00000000;
  wire r_mapped = (ar_word == `DRM_OFS_ROWMASK) || (ar_word == `DRM_OFS_DLY) ||
                  (ar_word == `DRM_OFS_LOWBITS) || (ar_word == `DRM_OFS_STATUS);

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `DRM_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= r_mapped ? `DRM_RESP_OKAY : `DRM_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------- row address ----------------
  wire [ADDR_W-1:0] addr_shift = user_addr >> row_bit_position;
  assign row_addr = row_addr_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) row_addr_r <= `DRM_RST_ROWMASK;
    else       row_addr_r <= addr_shift[`DRM_ROWMASK_W-1:0] & row_select_mask_r;
  end

  // ---------------- command gate ----------------
  wire normal    = state_r == DRM_ST_ACTIVE;
  wire stay_done = pwr_cnt_r == 9'h000;
  wire rd_same   = cmd.cs == last_wr_cs_r;
  wire rd_ok     = rd_same ? (same_cnt_r == 5'h00) : (cross_cnt_r == 5'h00);
  wire pre_ok    = wp_cnt_r[cmd.bank] == 5'h00;

  always_comb begin
    case (cmd.kind)
      DRM_CMD_WRITE:    cmd_ready = normal;
      DRM_CMD_READ:     cmd_ready = normal && rd_ok;
      DRM_CMD_PRECHG:   cmd_ready = normal && pre_ok;
      DRM_CMD_SR_ENTER: cmd_ready = normal;
      DRM_CMD_PD_ENTER: cmd_ready = normal;
      DRM_CMD_SR_EXIT:  cmd_ready = (state_r == DRM_ST_SELFREF) && stay_done;
      DRM_CMD_PD_EXIT:  cmd_ready = (state_r == DRM_ST_PWRDN) && stay_done;
      default:          cmd_ready = 1'b0;
    endcase
  end

  wire acc    = cmd_valid && cmd_ready;
  wire acc_wr = acc && (cmd.kind == DRM_CMD_WRITE);

  // power state machine; one timer serves both the stay and the exit wait
  always_comb begin
    state_nxt   = state_r;
    pwr_cnt_nxt = stay_done ? 9'h000 : pwr_cnt_r - 9'h001;
    case (state_r)
      DRM_ST_ACTIVE: begin
        if (acc && cmd.kind == DRM_CMD_SR_ENTER) begin
          state_nxt   = DRM_ST_SELFREF;
          pwr_cnt_nxt = {1'b0, selfrefresh_min_stay};
        end else if (acc && cmd.kind == DRM_CMD_PD_ENTER) begin
          state_nxt   = DRM_ST_PWRDN;
          pwr_cnt_nxt = {5'h00, powerdown_min_stay};
        end
      end
      DRM_ST_SELFREF: begin
        if (acc) begin
          state_nxt   = DRM_ST_SR_EXIT;
          pwr_cnt_nxt = selfrefresh_exit_wait;
        end
      end
      DRM_ST_PWRDN: begin
        if (acc) begin
          state_nxt   = DRM_ST_PD_EXIT;
          pwr_cnt_nxt = {3'h0, powerdown_exit_wait};
        end
      end
      DRM_ST_SR_EXIT: if (stay_done) state_nxt = DRM_ST_ACTIVE;
      DRM_ST_PD_EXIT: if (stay_done) state_nxt = DRM_ST_ACTIVE;
      default:        state_nxt = DRM_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= DRM_ST_ACTIVE;
      pwr_cnt_r <= 9'h000;
    end else begin
      state_r   <= state_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
    end
  end

  // write-to-read spacing; the last written chip select picks which counter gates a read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      same_cnt_r   <= 5'h00;
      cross_cnt_r  <= 5'h00;
      last_wr_cs_r <= 1'b0;
    end else if (acc_wr) begin
      same_cnt_r   <= write_read_same_cs_spacing;
      cross_cnt_r  <= write_read_cross_cs_spacing;
      last_wr_cs_r <= cmd.cs;
    end else begin
      if (same_cnt_r != 5'h00)  same_cnt_r  <= same_cnt_r - 5'h01;
      if (cross_cnt_r != 5'h00) cross_cnt_r <= cross_cnt_r - 5'h01;
    end
  end

  // one precharge timer per bank, so writes to other banks do not hide a pending one
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BANK; gb++) begin : g_bank
      wire load = acc_wr && (cmd.bank == 3'(gb));
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)                     wp_cnt_r[gb] <= 5'h00;
        else if (load)                 wp_cnt_r[gb] <= write_precharge_spacing;
        else if (wp_cnt_r[gb] != 5'h00) wp_cnt_r[gb] <= wp_cnt_r[gb] - 5'h01;
      end
    end
  endgenerate

  // next data request: a later write restarts the wait, only one is tracked
  wire ndr_due = ndr_pend_r && (ndr_cnt_r <= 5'h01);
  assign next_data_request = ndr_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ndr_pend_r <= 1'b0;
      ndr_cnt_r  <= 5'h00;
      ndr_r      <= 1'b0;
    end else begin
      ndr_r <= ndr_due && !acc_wr;
      if (acc_wr) begin
        ndr_pend_r <= 1'b1;
        // a zero spacing must not wrap the counter into a 32-cycle wait
        ndr_cnt_r  <= (next_data_request_spacing == 5'h00) ? 5'h00 : next_data_request_spacing - 5'h01;
      end else if (ndr_due) begin
        ndr_pend_r <= 1'b0;
      end else if (ndr_pend_r) begin
        ndr_cnt_r  <= ndr_cnt_r - 5'h01;
      end
    end
  end
endmodule // drm_ctrl

// file: drm_ctrl_chk.sv
// port assertions for the row mask and command spacing block
`timescale 1ns/1ns
module drm_ctrl_chk (
  // clock and reset
  input wire logic             clk,
  input wire logic             nrst,
  // register bus
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // command gate
  input wire logic             cmd_valid,
  input wire drm_pkg::drm_cmd_t cmd,
  input wire logic             cmd_ready,
  input wire logic             next_data_request
);
  import drm_pkg::*;
  logic [5:0] wr_age_r;
  logic       low_pwr_r;
  wire        take_w = cmd_valid && cmd_ready;
  wire        is_enter_w = cmd.kind inside {DRM_CMD_SR_ENTER, DRM_CMD_PD_ENTER};
  wire        is_exit_w = cmd.kind inside {DRM_CMD_SR_EXIT, DRM_CMD_PD_EXIT};
  // age saturates so an old write never looks recent again
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_age_r <= 6'h3F;
      low_pwr_r <= 1'b0;
    end else begin
      if (take_w && cmd.kind == DRM_CMD_WRITE) wr_age_r <= 6'h00;
      else if (wr_age_r != 6'h3F) wr_age_r <= wr_age_r + 6'h01;
      if (take_w && is_enter_w) low_pwr_r <= 1'b1;
      else if (take_w && is_exit_w) low_pwr_r <= 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before bready");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write response two cycles after address and data");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");
  a_ndr_after_wr: assert property (next_data_request |-> wr_age_r inside {[1:31]})
    else $error("next data request without a recent write");
  a_lowpwr_gate: assert property (low_pwr_r && !is_enter_w && !is_exit_w |-> !cmd_ready)
    else $error("normal command ready while in low power");
  a_enter_gate: assert property (low_pwr_r && is_enter_w |-> !cmd_ready)
    else $error("low power entry ready while not active");
  a_kind_unused: assert property (cmd.kind == 3'h7 |-> !cmd_ready)
    else $error("unused command kind ready");
endmodule // drm_ctrl_chk

bind drm_ctrl drm_ctrl_chk i_drm_ctrl_chk (
  .clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .next_data_request(next_data_request)
);

// file: drm_seq_mdl.sv
// command source that issues one or two back-to-back commands and times the gap
`timescale 1ns/1ns
module drm_seq_mdl (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // bench control
  input  wire logic              go,
  input  wire logic              two,
  input  wire drm_pkg::drm_cmd_t c0,
  input  wire drm_pkg::drm_cmd_t c1,
  output logic [5:0]             gap,
  output logic                   done,
  // command gate
  output logic                   cmd_valid,
  output drm_pkg::drm_cmd_t      cmd,
  input  wire logic              cmd_ready
);
  import drm_pkg::*;
  logic second_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_valid <= 1'b0;
      cmd <= drm_cmd_t'(7'h7F);
      second_r <= 1'b0;
      gap <= 6'h00;
      done <= 1'b0;
    end else if (go) begin
      cmd_valid <= 1'b1;
      cmd <= c0;
      second_r <= 1'b0;
      done <= 1'b0;
    end else if (cmd_valid && cmd_ready && two && !second_r) begin
      cmd <= c1;
      second_r <= 1'b1;
      gap <= 6'h01;
    end else if (cmd_valid && cmd_ready) begin
      // released bus shows the inverse so a stale command cannot pass
      cmd_valid <= 1'b0;
      cmd <= drm_cmd_t'(~cmd);
      done <= 1'b1;
    end else if (cmd_valid && second_r) begin
      gap <= gap + 6'h01;
    end
  end
endmodule // drm_seq_mdl

// file: tb.sv
// self-checking bench for the row mask and command spacing block
`timescale 1ns/1ns
`include "drm_cfg.svh"
module tb;
  import drm_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic        go = 1'b0, two = 1'b0, aw_rdy, w_rdy, b_v, ar_rdy, r_v, cmd_v, cmd_rdy, ndr, done;
  logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
  logic [31:0] w_d = 32'h0, u_a = 32'h0, q, r_d;
  logic [3:0]  w_s = 4'h0;
  logic [4:0]  rbp = 5'h00;
  logic [1:0]  b_resp, r_resp, r;
  logic [12:0] row_a;
  logic [5:0]  gap, age = 6'h00, ndr_age = 6'h00;
  drm_cmd_t    cmd_b, c0 = '0, c1 = '0;
  int          err_total = 0, compares = 0;
  always #5 clk = ~clk;
  drm_ctrl i_drm_ctrl (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .user_addr(u_a), .row_bit_position(rbp), .row_addr(row_a), .cmd_valid(cmd_v), .cmd(cmd_b),
    .cmd_ready(cmd_rdy), .next_data_request(ndr)
  ); // i_drm_ctrl
  drm_seq_mdl i_drm_seq_mdl (
    .clk(clk), .nrst(nrst), .go(go), .two(two), .c0(c0), .c1(c1), .gap(gap), .done(done),
    .cmd_valid(cmd_v), .cmd(cmd_b), .cmd_ready(cmd_rdy)
  ); // i_drm_seq_mdl
  // cycles from the last accepted write to the data request pulse
  always @(posedge clk) begin
    age <= (cmd_v && cmd_rdy && cmd_b.kind == DRM_CMD_WRITE) ? 6'h00 : age + 6'h01;
    if (ndr === 1'b1) ndr_age <= age;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    aw_a <= a;
    ar_a <= a;
    w_d <= d;
    w_s <= s;
    aw_v <= wr;
    w_v <= wr;
    b_r <= wr;
    ar_v <= !wr;
    r_r <= !wr;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
      if (ar_v && ar_rdy) ar_v <= 1'b0;
      if ((b_r && b_v) || (r_r && r_v)) begin
        q = r_d;
        r = wr ? b_resp : r_resp;
        b_r <= 1'b0;
        r_r <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    axi(1'b0, a, 32'h0, 4'h0);
    chk("rdata", e, q);
  endtask
  // one or two commands; the gap is only meaningful for two
  task automatic pair(input logic t, input drm_cmd_t a, input drm_cmd_t b, input logic [5:0] e);
    int n;
    @(posedge clk);
    go <= 1'b1;
    two <= t;
    c0 <= a;
    c1 <= b;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    if (n == 100) begin
      err_total++;
      end_sim();
    end else if (t) chk("gap", {26'h0, e}, {26'h0, gap});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(`DRM_OFS_ROWMASK, 32'h0);
    rd(`DRM_OFS_DLY, 32'h0);
    rd(`DRM_OFS_LOWBITS, 32'h0);
    $display("test reset done");
    axi(1'b1, `DRM_OFS_ROWMASK, 32'hFFFFFFFF, 4'hF);
    rd(`DRM_OFS_ROWMASK, 32'h00001FFF);
    axi(1'b1, `DRM_OFS_DLY, 32'hFFFFFFFF, 4'hF);
    rd(`DRM_OFS_DLY, 32'h7FFFFFFF);
    axi(1'b1, `DRM_OFS_DLY, 32'h0, 4'h1);
    rd(`DRM_OFS_DLY, 32'h7FFFFF00);
    axi(1'b1, 12'h010, 32'h1, 4'hF);
    chk("bresp", 32'h3, {30'h0, r});
    rd(12'h010, 32'h0);
    chk("rresp", 32'h3, {30'h0, r});
    $display("test registers done");
    axi(1'b1, `DRM_OFS_ROWMASK, 32'h000000FF, 4'hF);
    u_a <= 32'h00012345;
    rbp <= 5'h04;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("row_addr", 32'h34, {19'h0, row_a});
    $display("test row address done");
    // self-refresh 5 stay 3 exit, power-down 2 stay 4 exit, same-cs spacing 17
    axi(1'b1, `DRM_OFS_DLY, 32'h08420305, 4'hF);
    axi(1'b1, `DRM_OFS_LOWBITS, 32'h00004123, 4'hF);
    // a gated command is taken one edge after its spacing counter reaches zero
    pair(1'b1, '{DRM_CMD_WRITE, 1'b0, 3'h1}, '{DRM_CMD_READ, 1'b0, 3'h0}, 6'h12);
    // pulse stands in the third cycle after the write; age lags the pulse by one edge
    chk("ndr_age", 32'h2, {26'h0, ndr_age});
    pair(1'b1, '{DRM_CMD_WRITE, 1'b0, 3'h1}, '{DRM_CMD_READ, 1'b1, 3'h0}, 6'h03);
    pair(1'b1, '{DRM_CMD_WRITE, 1'b0, 3'h1}, '{DRM_CMD_PRECHG, 1'b0, 3'h1}, 6'h05);
    pair(1'b1, '{DRM_CMD_WRITE, 1'b0, 3'h1}, '{DRM_CMD_PRECHG, 1'b0, 3'h2}, 6'h01);
    $display("test write spacing done");
    pair(1'b1, '{DRM_CMD_SR_ENTER, 1'b0, 3'h0}, '{DRM_CMD_SR_EXIT, 1'b0, 3'h0}, 6'h06);
    pair(1'b0, '{DRM_CMD_SR_ENTER, 1'b0, 3'h0}, '{DRM_CMD_SR_EXIT, 1'b0, 3'h0}, 6'h00);
    pair(1'b1, '{DRM_CMD_SR_EXIT, 1'b0, 3'h0}, '{DRM_CMD_WRITE, 1'b0, 3'h0}, 6'h05);
    pair(1'b1, '{DRM_CMD_PD_ENTER, 1'b0, 3'h0}, '{DRM_CMD_PD_EXIT, 1'b0, 3'h0}, 6'h03);
    pair(1'b0, '{DRM_CMD_PD_ENTER, 1'b0, 3'h0}, '{DRM_CMD_PD_EXIT, 1'b0, 3'h0}, 6'h00);
    pair(1'b1, '{DRM_CMD_PD_EXIT, 1'b0, 3'h0}, '{DRM_CMD_WRITE, 1'b1, 3'h0}, 6'h06);
    $display("test power states done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`DRM_OFS_DLY, 32'h0);
    rd(`DRM_OFS_LOWBITS, 32'h0);
    rd(`DRM_OFS_STATUS, 32'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule // tb
